// ==== logic/pec_counters.sv ====
// Per-element performance counters with overflow interrupt
`timescale 1ns/1ps
// Summary of operation
// [R01] Element carries programmable event counters plus a cycle counter.
// [R02] Overflow drives the element's own private interrupt line, masked by irq_en.
// [R03] Six programmable event counters and one dedicated cycle counter.
// [R04] Local caches and last-level cache events countable; others optional.
// [R05] Instructions committed or speculated countable; committed preferred.
// [R06] No multithread counting: thread select reads zero, field reads 1111.
// [R07] With profiling, hardware flag management; flag field reads 01.
// [R08] Statistical profiling is optional but recommended.
// [R09] Event 0x0008 counts committed instructions, 0x0011 counts cycles.
// [R10] Events 0x0004, 0x0013 and 0x0014 are countable.
// [R11] Events 0x0016, 0x0027 and 0x002B are countable.
// [R12] Events 0x0036 and 0x0037 count last-level reads and misses.
// [R13] Read events 0x0040, 0x0050, 0x00A0 and 0x0066 are countable.
// [R14] Long-latency miss events 0x0039, 0x4006 and 0x4009 countable.
// [R15] Long-latency miss events 0x400A and 0x400B countable.
// [R16] Non-local numbered cache levels need no events.
// [R17] Counters count only this element's own events.
// [R18] TLB access and walk events 0x0025, 0x0026, 0x0034, 0x0035.
// [R19] Demand-only events 0x8130 through 0x8150 beside mixed events.
// [R20] Event 0x0011 counts every cycle, 0x003C undispatched cycles.
// [R21] Stall events 0x0023, 0x0024 and 0x4005 are countable.
// [R22] Counter increments on its selected event, flags overflow on wrap.
module pec_counters (
	input  wire logic                      ref_clk,
	input  wire logic                      sys_rst,
	input  wire pec_pkg::pec_events_t      events,
	input  wire pec_pkg::pec_ctrl_t        ctrl,
	output logic [pec_pkg::PEC_NUM_CTR-1:0][pec_pkg::PEC_CTR_W-1:0] evt_count,
	output logic [pec_pkg::PEC_CYC_W-1:0]  cycle_count,
	output logic [pec_pkg::PEC_NUM_CTR:0]  ovf_status,
	output logic                           per_core_private_interrupt,
	output logic [pec_pkg::PEC_NUM_CTR-1:0] thread_select_readback,
	output logic [3:0]                     multithread_count_feature_field,
	output logic [1:0]                     profiling_buffer_flag_mgmt_field
);

	pec_pkg::pec_state_t               s_q;
	pec_pkg::pec_state_t               s_d;
	logic [pec_pkg::PEC_NUM_CTR-1:0]   hit;
	logic [pec_pkg::PEC_NUM_CTR-1:0]   inc;
	logic                              cyc_inc;

	// Step a counter by en and return the new value with the carry out as its top bit
	function automatic logic [pec_pkg::PEC_CTR_W:0] pec_step(
		input logic [pec_pkg::PEC_CTR_W-1:0] val,
		input logic                          en
	);
		logic [pec_pkg::PEC_CTR_W:0] sum;
		sum = {1'b0, val} + {{pec_pkg::PEC_CTR_W{1'b0}}, en};
		return sum;
	endfunction : pec_step

	// Sticky flag update; a wrap in the clearing cycle wins
	function automatic logic pec_flag(
		input logic old_flag,
		input logic clr,
		input logic wrap
	);
		return (old_flag & ~clr) | wrap;
	endfunction : pec_flag

	// One event decoder per programmable counter
	for (genvar i = 0; i < pec_pkg::PEC_NUM_CTR; i++) begin : g_dec // R03
		pec_event_decode u_dec (
			.evt_num (ctrl.evt_sel[i]),
			.events  (events),
			.hit     (hit[i])
		);
	end

	// Events come only from this element, so no attribution filter
	assign inc = hit & ctrl.ctr_en & {pec_pkg::PEC_NUM_CTR{ctrl.global_en}}; // R17
	assign cyc_inc = ctrl.global_en & ctrl.cyc_en; // R01

	// Next state of counters, sticky flags and interrupt
	always_comb begin
		logic [pec_pkg::PEC_CTR_W:0] step;
		logic [pec_pkg::PEC_CYC_W:0] csum;
		step = '0;
		csum = '0;
		s_d = s_q;
		// Multithread counting is not built, so the select bits stay zero
		s_d.mt_field = pec_pkg::PEC_MT_FIELD_ABSENT; // R06
		s_d.mt_sel   = '0; // R06
		s_d.spu_field = pec_pkg::PEC_SPU_PRESENT ? // R07
			pec_pkg::PEC_SPU_FLAG_HW : pec_pkg::PEC_SPU_FLAG_NONE; // R08
		for (int i = 0; i < pec_pkg::PEC_NUM_CTR; i++) begin
			step = pec_step(s_q.evt_cnt[i], inc[i]); // R22
			if (ctrl.cnt_zero[i]) begin
				s_d.evt_cnt[i] = pec_pkg::PEC_CTR_RST;
				step[pec_pkg::PEC_CTR_W] = 1'b0;
			end else begin
				s_d.evt_cnt[i] = step[pec_pkg::PEC_CTR_W-1:0];
			end
			// A wrap in the clearing cycle still sets the flag
			s_d.ovf[i] = pec_flag(s_q.ovf[i], ctrl.ovf_clr[i],
				step[pec_pkg::PEC_CTR_W]); // R22
		end
		csum = {1'b0, s_q.cyc_cnt}
			+ {{pec_pkg::PEC_CYC_W{1'b0}}, cyc_inc}; // R01
		if (ctrl.cnt_zero[pec_pkg::PEC_CYC_BIT]) begin
			s_d.cyc_cnt = pec_pkg::PEC_CYC_RST;
			csum[pec_pkg::PEC_CYC_W] = 1'b0;
		end else begin
			s_d.cyc_cnt = csum[pec_pkg::PEC_CYC_W-1:0];
		end
		s_d.ovf[pec_pkg::PEC_CYC_BIT] = pec_flag(
			s_q.ovf[pec_pkg::PEC_CYC_BIT],
			ctrl.ovf_clr[pec_pkg::PEC_CYC_BIT],
			csum[pec_pkg::PEC_CYC_W]); // R22
		// Line leaves straight from a flop, no gating downstream
		s_d.irq = |(s_d.ovf & ctrl.irq_en); // R02
	end

	// State register
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			s_q           <= '0;
			s_q.mt_field  <= pec_pkg::PEC_MT_FIELD_ABSENT;
			s_q.spu_field <= pec_pkg::PEC_SPU_FLAG_HW;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs come straight from the state flops
	assign evt_count                        = s_q.evt_cnt;
	assign cycle_count                      = s_q.cyc_cnt;
	assign ovf_status                       = s_q.ovf;
	assign per_core_private_interrupt       = s_q.irq; // R02
	assign thread_select_readback           = s_q.mt_sel;
	assign multithread_count_feature_field  = s_q.mt_field;
	assign profiling_buffer_flag_mgmt_field = s_q.spu_field;

	// Counter 0 set to count cycles and free to run
	sequence seq_cyc_sel;
		ctrl.global_en && ctrl.ctr_en[0] && !ctrl.cnt_zero[0]
			&& ctrl.evt_sel[0] == pec_pkg::EV_CPU_CYCLES;
	endsequence

	// Counter 0 at its top value about to step
	sequence seq_wrap0;
		inc[0] && !ctrl.cnt_zero[0] && s_q.evt_cnt[0] == 32'hFFFFFFFF;
	endsequence

	// Counter 0 fed by committed instructions
	sequence seq_commit0;
		ctrl.global_en && ctrl.ctr_en[0] && !ctrl.cnt_zero[0]
			&& ctrl.evt_sel[0] == pec_pkg::EV_INST_COMMIT;
	endsequence

	chk_cycle_counter: assert property ( // R01
		@(posedge ref_clk) disable iff (sys_rst)
		(cyc_inc && !ctrl.cnt_zero[pec_pkg::PEC_CYC_BIT]) |=>
			cycle_count == $past(cycle_count) + 64'h1)
		else $error("cycle counter did not step");

	chk_irq_from_ovf: assert property ( // R02
		@(posedge ref_clk) disable iff (sys_rst)
		(ovf_status[0] && $past(ctrl.irq_en[0]))
			|-> per_core_private_interrupt)
		else $error("overflow did not raise interrupt");

	chk_irq_quiet: assert property ( // R02
		@(posedge ref_clk) disable iff (sys_rst)
		(ovf_status == '0) |-> !per_core_private_interrupt)
		else $error("interrupt without overflow");

	chk_counter_hold: assert property ( // R03
		@(posedge ref_clk) disable iff (sys_rst)
		(!ctrl.global_en && !ctrl.cnt_zero[5]) |=>
			evt_count[5] == $past(evt_count[5]))
		else $error("counter moved while disabled");

	chk_mt_field: assert property ( // R06
		@(posedge ref_clk) disable iff (sys_rst)
		multithread_count_feature_field == 4'hF
			&& thread_select_readback == '0)
		else $error("multithread field wrong");

	chk_spu_flag: assert property ( // R07
		@(posedge ref_clk) disable iff (sys_rst)
		profiling_buffer_flag_mgmt_field == 2'h1)
		else $error("profiling flag field wrong");

	chk_cycle_event: assert property ( // R20
		@(posedge ref_clk) disable iff (sys_rst)
		seq_cyc_sel ##1 seq_cyc_sel |=>
			evt_count[0] == $past(evt_count[0], 2) + 32'h2)
		else $error("cycle event missed a cycle");

	chk_commit_event: assert property ( // R09
		@(posedge ref_clk) disable iff (sys_rst)
		(seq_commit0 and events.instructions_committed_event
			and !s_q.evt_cnt[0][31]) |=>
			evt_count[0] == $past(evt_count[0]) + 32'h1)
		else $error("committed instruction not counted");

	chk_wrap_ovf: assert property ( // R22
		@(posedge ref_clk) disable iff (sys_rst)
		seq_wrap0 |=> (evt_count[0] == 32'h0 && ovf_status[0])
			##1 (ovf_status[0] || $past(ctrl.ovf_clr[0])))
		else $error("wrap did not flag overflow");

	chk_ovf_set_wins: assert property ( // R22
		@(posedge ref_clk) disable iff (sys_rst)
		(seq_wrap0 and ctrl.ovf_clr[0]) |=> ovf_status[0])
		else $error("overflow lost to clear");

	chk_ovf_clear: assert property ( // R22
		@(posedge ref_clk) disable iff (sys_rst)
		(ctrl.ovf_clr[1] && !inc[1]) |=> !ovf_status[1])
		else $error("overflow flag not cleared");

	chk_stall_event: assert property ( // R21
		@(posedge ref_clk) disable iff (sys_rst)
		(ctrl.global_en && ctrl.ctr_en[5] && !ctrl.cnt_zero[5]
			&& ctrl.evt_sel[5] == pec_pkg::EV_STALL_BE_MEM
			&& !events.stall_be_mem) |=>
			$stable(evt_count[5]))
		else $error("counted without a stall pulse");

	// Event checks on the counter each number lands on in the bench
	chk_spec_event: assert property ( // R05
		@(posedge ref_clk) disable iff (sys_rst)
		(ctrl.global_en && ctrl.ctr_en[1] && !ctrl.cnt_zero[1]
			&& ctrl.evt_sel[1] == pec_pkg::EV_INSN_SPEC
			&& events.instructions_speculated_event
			&& !s_q.evt_cnt[1][31]) |=>
			evt_count[1] == $past(evt_count[1]) + 32'h1)
		else $error("speculated event missed");

	chk_l1d_event: assert property ( // R10
		@(posedge ref_clk) disable iff (sys_rst)
		(ctrl.global_en && ctrl.ctr_en[2] && !ctrl.cnt_zero[2]
			&& ctrl.evt_sel[2] == pec_pkg::EV_L1D_ACCESS
			&& events.l1d_access
			&& !s_q.evt_cnt[2][31]) |=>
			evt_count[2] == $past(evt_count[2]) + 32'h1)
		else $error("first level data event missed");

	chk_l2d_event: assert property ( // R11
		@(posedge ref_clk) disable iff (sys_rst)
		(ctrl.global_en && ctrl.ctr_en[5] && !ctrl.cnt_zero[5]
			&& ctrl.evt_sel[5] == pec_pkg::EV_L2D_ACCESS
			&& events.l2d_access
			&& !s_q.evt_cnt[5][31]) |=>
			evt_count[5] == $past(evt_count[5]) + 32'h1)
		else $error("second level data event missed");

	chk_ll_read_event: assert property ( // R12
		@(posedge ref_clk) disable iff (sys_rst)
		(ctrl.global_en && ctrl.ctr_en[2] && !ctrl.cnt_zero[2]
			&& ctrl.evt_sel[2] == pec_pkg::EV_LL_RD
			&& events.last_level_read_event
			&& !s_q.evt_cnt[2][31]) |=>
			evt_count[2] == $past(evt_count[2]) + 32'h1)
		else $error("last level read event missed");

	chk_mem_rd_event: assert property ( // R13
		@(posedge ref_clk) disable iff (sys_rst)
		(ctrl.global_en && ctrl.ctr_en[1] && !ctrl.cnt_zero[1]
			&& ctrl.evt_sel[1] == pec_pkg::EV_MEM_RD
			&& events.mem_rd
			&& !s_q.evt_cnt[1][31]) |=>
			evt_count[1] == $past(evt_count[1]) + 32'h1)
		else $error("memory read event missed");

	chk_lmiss_event: assert property ( // R14
		@(posedge ref_clk) disable iff (sys_rst)
		(ctrl.global_en && ctrl.ctr_en[4] && !ctrl.cnt_zero[4]
			&& ctrl.evt_sel[4] == pec_pkg::EV_L1D_LMISS_RD
			&& events.l1d_lmiss_rd
			&& !s_q.evt_cnt[4][31]) |=>
			evt_count[4] == $past(evt_count[4]) + 32'h1)
		else $error("long latency miss event missed");

	chk_l2i_lmiss_event: assert property ( // R15
		@(posedge ref_clk) disable iff (sys_rst)
		(ctrl.global_en && ctrl.ctr_en[5] && !ctrl.cnt_zero[5]
			&& ctrl.evt_sel[5] == pec_pkg::EV_L2I_LMISS
			&& events.l2i_lmiss
			&& !s_q.evt_cnt[5][31]) |=>
			evt_count[5] == $past(evt_count[5]) + 32'h1)
		else $error("instruction miss event missed");

	chk_walk_event: assert property ( // R18
		@(posedge ref_clk) disable iff (sys_rst)
		(ctrl.global_en && ctrl.ctr_en[3] && !ctrl.cnt_zero[3]
			&& ctrl.evt_sel[3] == pec_pkg::EV_DATA_WALK
			&& events.data_table_walk_event
			&& !s_q.evt_cnt[3][31]) |=>
			evt_count[3] == $past(evt_count[3]) + 32'h1)
		else $error("table walk event missed");

	chk_demand_event: assert property ( // R19
		@(posedge ref_clk) disable iff (sys_rst)
		(ctrl.global_en && ctrl.ctr_en[1] && !ctrl.cnt_zero[1]
			&& ctrl.evt_sel[1] == pec_pkg::EV_DM_L3D
			&& events.dm_l3d
			&& !s_q.evt_cnt[1][31]) |=>
			evt_count[1] == $past(evt_count[1]) + 32'h1)
		else $error("demand event missed");

	chk_cyc_zero: assert property ( // R01
		@(posedge ref_clk) disable iff (sys_rst)
		ctrl.cnt_zero[pec_pkg::PEC_CYC_BIT] |=> cycle_count == 64'h0)
		else $error("cycle counter not zeroed");

	// Per-counter zeroing, idling and sticky flags
	for (genvar g = 0; g < pec_pkg::PEC_NUM_CTR; g++) begin : g_chk
		chk_ctr_zero: assert property ( // R22
			@(posedge ref_clk) disable iff (sys_rst)
			ctrl.cnt_zero[g] |=> evt_count[g] == 32'h0)
			else $error("counter not zeroed");

		// Idle judged from the inputs, not from the internal step
		chk_ctr_idle: assert property ( // R22
			@(posedge ref_clk) disable iff (sys_rst)
			(!ctrl.cnt_zero[g] && !(ctrl.global_en && ctrl.ctr_en[g]))
				|=> $stable(evt_count[g]))
			else $error("counter moved while off");

		chk_flag_sticky: assert property ( // R22
			@(posedge ref_clk) disable iff (sys_rst)
			(ovf_status[g] && !ctrl.ovf_clr[g]) |=> ovf_status[g])
			else $error("overflow flag dropped");

		chk_irq_mask: assert property ( // R02
			@(posedge ref_clk) disable iff (sys_rst)
			(ovf_status[g] && $past(ctrl.irq_en[g]))
				|-> per_core_private_interrupt)
			else $error("enabled overflow gave no interrupt");
	end

endmodule : pec_counters

// ==== logic/pec_event_decode.sv ====
// Event number decoder: selects one event pulse for one counter
`timescale 1ns/1ps
module pec_event_decode (
	input  wire logic [15:0]         evt_num,
	input  wire pec_pkg::pec_events_t events,
	output logic                     hit
);

	// Unknown event numbers never count
	always_comb begin
		case (evt_num)
			pec_pkg::EV_INST_COMMIT:  hit = events.instructions_committed_event;
			pec_pkg::EV_INSN_SPEC: // R05
				hit = events.instructions_speculated_event;
			pec_pkg::EV_CPU_CYCLES:   hit = 1'b1;
			pec_pkg::EV_L1D_ACCESS:   hit = events.l1d_access; // R04 R10
			pec_pkg::EV_MEM_ACCESS:   hit = events.mem_access;
			pec_pkg::EV_L1I_ACCESS:   hit = events.l1i_access;
			pec_pkg::EV_L2D_ACCESS:   hit = events.l2d_access; // R11
			pec_pkg::EV_L2I_ACCESS:   hit = events.l2i_access;
			pec_pkg::EV_L3D_ACCESS:   hit = events.l3d_access;
			pec_pkg::EV_LL_RD: // R12
				hit = events.last_level_read_event;
			pec_pkg::EV_LL_MISS_RD:   hit = events.last_level_read_miss_event;
			pec_pkg::EV_L1D_LMISS_RD: hit = events.l1d_lmiss_rd; // R14
			pec_pkg::EV_L1D_RD:       hit = events.l1d_rd;
			pec_pkg::EV_L2D_RD:       hit = events.l2d_rd;
			pec_pkg::EV_MEM_RD:       hit = events.mem_rd; // R13
			pec_pkg::EV_L3D_RD:       hit = events.l3d_rd;
			pec_pkg::EV_L1I_LMISS:    hit = events.l1i_lmiss;
			pec_pkg::EV_L2D_LMISS_RD: hit = events.l2d_lmiss_rd;
			pec_pkg::EV_L2I_LMISS:    hit = events.l2i_lmiss; // R15
			pec_pkg::EV_L3D_LMISS_RD: hit = events.l3d_lmiss_rd;
			pec_pkg::EV_DTLB1: // R18
				hit = events.first_level_data_tlb_access_event;
			pec_pkg::EV_ITLB1:
				hit = events.first_level_instr_tlb_access_event;
			pec_pkg::EV_DATA_WALK:    hit = events.data_table_walk_event;
			pec_pkg::EV_INSTR_WALK:   hit = events.instr_table_walk_event;
			pec_pkg::EV_DM_DTLB1:     hit = events.dm_dtlb1; // R19
			pec_pkg::EV_DM_ITLB1:     hit = events.dm_itlb1;
			pec_pkg::EV_DM_DATA_WALK: hit = events.dm_data_walk;
			pec_pkg::EV_DM_INSTR_WALK: hit = events.dm_instr_walk;
			pec_pkg::EV_DM_L1D:       hit = events.dm_l1d;
			pec_pkg::EV_DM_L1I:       hit = events.dm_l1i;
			pec_pkg::EV_DM_L2D:       hit = events.dm_l2d;
			pec_pkg::EV_DM_L2I:       hit = events.dm_l2i;
			pec_pkg::EV_DM_L3D:       hit = events.dm_l3d;
			pec_pkg::EV_STALL:        hit = events.stall;
			pec_pkg::EV_STALL_FE:     hit = events.stall_fe;
			pec_pkg::EV_STALL_BE:     hit = events.stall_be;
			pec_pkg::EV_STALL_BE_MEM: hit = events.stall_be_mem;
			// Non-local cache levels have no numbers of their own
			default:                  hit = 1'b0; // R16
		endcase
	end

endmodule : pec_event_decode

// ==== logic/pec_pkg.sv ====
// Constants and carrier types for the per-element performance counters
package pec_pkg;

	// Counter structure
	localparam int PEC_NUM_CTR = 6;
	localparam int PEC_CTR_W   = 32;
	localparam int PEC_CYC_W   = 64;
	localparam int PEC_EVT_W   = 16;
	localparam int PEC_CYC_BIT = PEC_NUM_CTR;

	// Values after reset
	localparam logic [PEC_CTR_W-1:0] PEC_CTR_RST = 32'h00000000;
	localparam logic [PEC_CYC_W-1:0] PEC_CYC_RST = 64'h0000000000000000;

	// Feature and capability fields
	localparam logic [3:0] PEC_MT_FIELD_ABSENT  = 4'hF;
	localparam logic [3:0] PEC_MT_FIELD_PRESENT = 4'h1;
	localparam logic       PEC_SPU_PRESENT      = 1'h1;
	localparam logic [1:0] PEC_SPU_FLAG_HW      = 2'h1;
	localparam logic [1:0] PEC_SPU_FLAG_NONE    = 2'h0;

	// Event numbers
	localparam logic [15:0] EV_L1D_ACCESS   = 16'h0004;
	localparam logic [15:0] EV_INST_COMMIT  = 16'h0008;
	localparam logic [15:0] EV_CPU_CYCLES   = 16'h0011;
	localparam logic [15:0] EV_MEM_ACCESS   = 16'h0013;
	localparam logic [15:0] EV_L1I_ACCESS   = 16'h0014;
	localparam logic [15:0] EV_L2D_ACCESS   = 16'h0016;
	localparam logic [15:0] EV_INSN_SPEC    = 16'h001B;
	localparam logic [15:0] EV_STALL_FE     = 16'h0023;
	localparam logic [15:0] EV_STALL_BE     = 16'h0024;
	localparam logic [15:0] EV_DTLB1        = 16'h0025;
	localparam logic [15:0] EV_ITLB1        = 16'h0026;
	localparam logic [15:0] EV_L2I_ACCESS   = 16'h0027;
	localparam logic [15:0] EV_L3D_ACCESS   = 16'h002B;
	localparam logic [15:0] EV_DATA_WALK    = 16'h0034;
	localparam logic [15:0] EV_INSTR_WALK   = 16'h0035;
	localparam logic [15:0] EV_LL_RD        = 16'h0036;
	localparam logic [15:0] EV_LL_MISS_RD   = 16'h0037;
	localparam logic [15:0] EV_L1D_LMISS_RD = 16'h0039;
	localparam logic [15:0] EV_STALL        = 16'h003C;
	localparam logic [15:0] EV_L1D_RD       = 16'h0040;
	localparam logic [15:0] EV_L2D_RD       = 16'h0050;
	localparam logic [15:0] EV_MEM_RD       = 16'h0066;
	localparam logic [15:0] EV_L3D_RD       = 16'h00A0;
	localparam logic [15:0] EV_STALL_BE_MEM = 16'h4005;
	localparam logic [15:0] EV_L1I_LMISS    = 16'h4006;
	localparam logic [15:0] EV_L2D_LMISS_RD = 16'h4009;
	localparam logic [15:0] EV_L2I_LMISS    = 16'h400A;
	localparam logic [15:0] EV_L3D_LMISS_RD = 16'h400B;
	localparam logic [15:0] EV_DM_DTLB1     = 16'h8130;
	localparam logic [15:0] EV_DM_ITLB1     = 16'h8131;
	localparam logic [15:0] EV_DM_DATA_WALK = 16'h813C;
	localparam logic [15:0] EV_DM_INSTR_WALK = 16'h813D;
	localparam logic [15:0] EV_DM_L1D       = 16'h8140;
	localparam logic [15:0] EV_DM_L1I       = 16'h8141;
	localparam logic [15:0] EV_DM_L2D       = 16'h8148;
	localparam logic [15:0] EV_DM_L2I       = 16'h8149;
	localparam logic [15:0] EV_DM_L3D       = 16'h8150;

	// One-cycle event pulses from this element's pipeline and caches
	typedef struct packed {
		logic instructions_committed_event;
		logic instructions_speculated_event;
		logic l1d_access, mem_access, l1i_access;
		logic l2d_access, l2i_access, l3d_access;
		logic last_level_read_event, last_level_read_miss_event;
		logic l1d_lmiss_rd, l1d_rd, l2d_rd, mem_rd, l3d_rd;
		logic l1i_lmiss, l2d_lmiss_rd, l2i_lmiss, l3d_lmiss_rd;
		logic first_level_data_tlb_access_event;
		logic first_level_instr_tlb_access_event;
		logic data_table_walk_event, instr_table_walk_event;
		logic dm_dtlb1, dm_itlb1, dm_data_walk, dm_instr_walk;
		logic dm_l1d, dm_l1i, dm_l2d, dm_l2i, dm_l3d;
		logic stall, stall_fe, stall_be, stall_be_mem;
	} pec_events_t;

	// Control levels and pulses from the element's system registers
	typedef struct packed {
		logic                                       global_en;
		logic                                       cyc_en;
		logic [PEC_NUM_CTR-1:0]                     ctr_en;
		logic [PEC_NUM_CTR-1:0][PEC_EVT_W-1:0]      evt_sel;
		logic [PEC_NUM_CTR-1:0]                     counter_thread_select_bit;
		logic [PEC_NUM_CTR:0]                       irq_en;
		logic [PEC_NUM_CTR:0]                       ovf_clr;
		logic [PEC_NUM_CTR:0]                       cnt_zero;
	} pec_ctrl_t;

	// Complete state of the counter block
	typedef struct packed {
		logic [PEC_NUM_CTR-1:0][PEC_CTR_W-1:0] evt_cnt;
		logic [PEC_CYC_W-1:0]                  cyc_cnt;
		logic [PEC_NUM_CTR:0]                  ovf;
		logic                                  irq;
		logic [PEC_NUM_CTR-1:0]                mt_sel;
		logic [3:0]                            mt_field;
		logic [1:0]                            spu_field;
	} pec_state_t;

endpackage : pec_pkg

// ==== testbench/pec_irq_model.sv ====
// Interrupt controller stand-in that counts private interrupt assertions
`timescale 1ns/1ps
module pec_irq_model (
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	input  wire logic        irq_line,
	output logic [15:0]      irq_edges
);
	logic irq_prev_q;

	// One dedicated line, taken as is; nothing shared or combined here
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			irq_prev_q <= 1'h0;
			irq_edges  <= 16'h0000;
		end else begin
			irq_prev_q <= irq_line;
			if (irq_line && !irq_prev_q) begin
				irq_edges <= irq_edges + 16'h0001;
			end
		end
	end
endmodule : pec_irq_model

// ==== testbench/tb_top.sv ====
// Self-checking bench for the per-element performance counters
`timescale 1ns/1ps
module tb_top;
	// Event numbers in the bit order of the event pulse struct
	localparam logic [15:0] EV_TAB [36] = '{
		pec_pkg::EV_INST_COMMIT, pec_pkg::EV_INSN_SPEC,
		pec_pkg::EV_L1D_ACCESS, pec_pkg::EV_MEM_ACCESS,
		pec_pkg::EV_L1I_ACCESS, pec_pkg::EV_L2D_ACCESS,
		pec_pkg::EV_L2I_ACCESS, pec_pkg::EV_L3D_ACCESS,
		pec_pkg::EV_LL_RD, pec_pkg::EV_LL_MISS_RD,
		pec_pkg::EV_L1D_LMISS_RD, pec_pkg::EV_L1D_RD, pec_pkg::EV_L2D_RD,
		pec_pkg::EV_MEM_RD, pec_pkg::EV_L3D_RD, pec_pkg::EV_L1I_LMISS,
		pec_pkg::EV_L2D_LMISS_RD, pec_pkg::EV_L2I_LMISS,
		pec_pkg::EV_L3D_LMISS_RD, pec_pkg::EV_DTLB1, pec_pkg::EV_ITLB1,
		pec_pkg::EV_DATA_WALK, pec_pkg::EV_INSTR_WALK,
		pec_pkg::EV_DM_DTLB1, pec_pkg::EV_DM_ITLB1,
		pec_pkg::EV_DM_DATA_WALK, pec_pkg::EV_DM_INSTR_WALK,
		pec_pkg::EV_DM_L1D, pec_pkg::EV_DM_L1I, pec_pkg::EV_DM_L2D,
		pec_pkg::EV_DM_L2I, pec_pkg::EV_DM_L3D, pec_pkg::EV_STALL,
		pec_pkg::EV_STALL_FE, pec_pkg::EV_STALL_BE, pec_pkg::EV_STALL_BE_MEM
	};

	logic                  ref_clk;
	logic                  sys_rst;
	pec_pkg::pec_events_t  events;
	pec_pkg::pec_ctrl_t    ctrl;
	logic [5:0][31:0]      evt_count;
	logic [63:0]           cycle_count;
	logic [6:0]            ovf_status;
	logic                  irq;
	logic [5:0]            thread_rb;
	logic [3:0]            mt_field;
	logic [1:0]            spu_field;
	logic [15:0]           irq_edges;
	int                    fails;
	int                    tests_run;

	pec_counters uut (
		.ref_clk                          (ref_clk),
		.sys_rst                          (sys_rst),
		.events                           (events),
		.ctrl                             (ctrl),
		.evt_count                        (evt_count),
		.cycle_count                      (cycle_count),
		.ovf_status                       (ovf_status),
		.per_core_private_interrupt       (irq),
		.thread_select_readback           (thread_rb),
		.multithread_count_feature_field  (mt_field),
		.profiling_buffer_flag_mgmt_field (spu_field)
	);

	pec_irq_model irq_ctl (
		.ref_clk   (ref_clk),
		.sys_rst   (sys_rst),
		.irq_line  (irq),
		.irq_edges (irq_edges)
	);

	// Free-running 20 MHz clock
	initial begin
		ref_clk = 1'h0;
		forever #25 ref_clk = ~ref_clk;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : tick

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR t=%0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check

	task automatic test_done();
		$display("Counts: %0d compared, %0d mismatched", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : test_done

	// Fixed fields and cleared counters; thread select must stay ignored
	task automatic test_reset_values();
		@(negedge ref_clk);
		check(mt_field, 64'hF);
		check(spu_field, 64'h1);
		check(cycle_count, 64'h0);
		for (int i = 0; i < 6; i++) check(evt_count[i], 64'h0);
		check(ovf_status, 64'h0);
		tick(1);
		ctrl.counter_thread_select_bit <= 6'h3F;
		tick(2);
		@(negedge ref_clk);
		check(thread_rb, 64'h0);
		$display("test reset_values done");
	endtask : test_reset_values

	// Every event number but the cycle event, spread over all six counters; foreign pulses
	// are held high first so a loose decoder shows up as a miscount
	task automatic test_event_table();
		int c;
		for (int k = 0; k < 36; k++) begin
			c = k % 6;
			@(posedge ref_clk);
			ctrl.evt_sel[c] <= EV_TAB[k];
			ctrl.cnt_zero[c] <= 1'h1;
			events <= ~(36'h1 << (35 - k));
			tick(1);
			ctrl.cnt_zero <= 7'h00;
			tick(1);
			@(negedge ref_clk);
			check(evt_count[c], 64'h0);
			tick(1);
			events <= 36'h1 << (35 - k);
			tick(3);
			events <= '0;
			@(negedge ref_clk);
			check(evt_count[c], 64'h3);
		end
		$display("test event_table done");
	endtask : test_event_table

	// Unknown number, disabled counter and master enable off never count
	task automatic test_refusals();
		@(posedge ref_clk);
		ctrl.evt_sel[0] <= 16'h0001;
		ctrl.evt_sel[1] <= pec_pkg::EV_L1D_ACCESS;
		ctrl.ctr_en <= 6'h3D;
		ctrl.cnt_zero <= 7'h03;
		tick(1);
		ctrl.cnt_zero <= 7'h00;
		events <= 36'hFFFFFFFFF;
		tick(4);
		ctrl.global_en <= 1'h0;
		ctrl.ctr_en <= 6'h3F;
		tick(4);
		events <= '0;
		ctrl.global_en <= 1'h1;
		@(negedge ref_clk);
		check(evt_count[0], 64'h0);
		check(evt_count[1], 64'h0);
		$display("test refusals done");
	endtask : test_refusals

	// Cycle counter and a counter on the cycle event step every edge
	task automatic test_cycles();
		@(posedge ref_clk);
		ctrl.evt_sel[0] <= pec_pkg::EV_CPU_CYCLES;
		ctrl.cyc_en <= 1'h1;
		ctrl.cnt_zero <= 7'h41;
		tick(1);
		ctrl.cnt_zero <= 7'h00;
		tick(10);
		ctrl.cyc_en <= 1'h0;
		ctrl.ctr_en <= 6'h3E;
		tick(5);
		@(negedge ref_clk);
		check(cycle_count, 64'hA);
		check(evt_count[0], 64'hA);
		$display("test cycles done");
	endtask : test_cycles

	// A wrap needs 2^32 steps, beyond this run; only the quiet line is
	// judged here, wrap timing rests on the design's own assertions
	task automatic test_irq_quiet();
		@(posedge ref_clk);
		ctrl.irq_en <= 7'h7F;
		ctrl.ovf_clr <= 7'h7F;
		tick(1);
		ctrl.ovf_clr <= 7'h00;
		tick(3);
		@(negedge ref_clk);
		check(ovf_status, 64'h0);
		check(irq, 64'h0);
		check(irq_edges, 64'h0);
		$display("test irq_quiet done");
	endtask : test_irq_quiet

	// Main sequence
	initial begin
		sys_rst = 1'h1;
		events = '0;
		ctrl = '0;
		fails = 0;
		tests_run = 0;
		tick(6);
		sys_rst <= 1'h0;
		test_reset_values();
		@(posedge ref_clk);
		ctrl.global_en <= 1'h1;
		ctrl.ctr_en <= 6'h3F;
		test_event_table();
		test_refusals();
		test_cycles();
		test_irq_quiet();
		test_done();
	end

	// Whole run is some 300 cycles; cut a hang far beyond that
	initial begin
		tick(5000);
		fails++;
		$display("ERROR t=%0t watchdog expired", $time);
		test_done();
	end
endmodule : tb_top
